// [rtl/status_flags.sv]
// Processor condition flags register with bank decode, power events and ALU flag update.
// Assumes the execution unit pulses event inputs for one clock and an Avalon-MM master.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`default_nettype none
module status_flags (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [status_flags_pkg::ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timer_expired,
    input wire status_flags_pkg::alu_op_type alu_op,
    input wire logic [7:0] alu_operand_a,
    input wire logic [7:0] alu_operand_b,
    input wire logic alu_start,
    input wire logic alu_dest_is_flags,
    input wire logic [8:0] direct_offset,
    input wire logic [7:0] indirect_pointer,
    output logic [8:0] direct_address,
    output logic [8:0] indirect_address,
    output logic [7:0] alu_result,
    output logic [7:0] processor_condition_flags_out
);
    import status_flags_pkg::*;

    // ==========================================================
    // Register state
    logic [7:0] processor_condition_flags;
    logic [7:0] alu_operand_a_reg;
    logic pending;
    logic [7:0] next_result;
    logic next_zero;
    logic next_digit_carry;
    logic next_carry;
    logic carries_valid;
    logic carry_valid;
    logic bus_write;
    logic [7:0] write_value;

    function automatic logic [8:0] bank_base(input logic [1:0] bank);
        bank_base = BANK_SIZE * {7'h00, bank};
    endfunction : bank_base

    // ==========================================================
    // Avalon-MM slave
    // Waitrequest is held one cycle so that reads always see settled flags.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pending <= 1'b0;
        end else begin
            pending <= (avs_read || avs_write) && !pending;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !pending;
    assign bus_write = avs_write && pending && avs_byteenable[0];
    assign write_value = (avs_writedata[7:0] & WRITABLE_MASK) |
        (processor_condition_flags & ~WRITABLE_MASK);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
            avs_response <= 2'h0;
        end else if (avs_read && !pending) begin
            avs_response <= 2'h0;
            case (avs_address)
                FLAGS_OFFSET: avs_readdata <= {24'h000000, processor_condition_flags};
                WORD_OFFSET: avs_readdata <= {24'h000000, alu_operand_a_reg};
                ALU_OFFSET: avs_readdata <= {24'h000000, alu_result};
                default: begin
                    avs_readdata <= 32'h00000000;
                    avs_response <= 2'h2;
                end
            endcase
        end else if (avs_write && !pending) begin
            avs_response <= (avs_address == FLAGS_OFFSET || avs_address == WORD_OFFSET) ?
                2'h0 : 2'h2;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alu_operand_a_reg <= 8'h00;
        end else if (bus_write && avs_address == WORD_OFFSET) begin
            alu_operand_a_reg <= avs_writedata[7:0];
        end
    end

    // ==========================================================
    // ALU
    flag_alu alu_unit (
        .op(alu_start ? alu_op : op_none_type_v),
        .operand_a(alu_operand_a),
        .operand_b(alu_operand_b),
        .carry_in(processor_condition_flags[CARRY_BIT]),
        .result(next_result),
        .zero(next_zero),
        .digit_carry(next_digit_carry),
        .carry(next_carry),
        .carries_valid(carries_valid),
        .carry_valid(carry_valid)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alu_result <= 8'h00;
        end else if (alu_start) begin
            alu_result <= next_result;
        end
    end

    // ==========================================================
    // Flags register
    // Software writes land first, so ALU flags and power events in the same cycle win.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            processor_condition_flags <= FLAGS_RESET;
        end else begin
            logic [7:0] v;
            v = processor_condition_flags;
            if (bus_write && avs_address == FLAGS_OFFSET) begin
                v = write_value;
            end
            if (alu_start && alu_dest_is_flags) begin
                v[7:5] = next_result[7:5];
            end
            if (alu_start && alu_op != op_rot_right && alu_op != op_rot_left) begin
                v[ZERO_BIT] = next_zero;
            end
            if (alu_start && carries_valid) begin
                v[DIGIT_CARRY_BIT] = next_digit_carry;
            end
            if (alu_start && carry_valid) begin
                v[CARRY_BIT] = next_carry;
            end
            if (watchdog_timer_expired) begin
                v[TIMEOUT_BIT] = 1'b0;
            end
            if (watchdog_clear_instr) begin
                v[TIMEOUT_BIT] = 1'b1;
                v[POWER_DOWN_BIT] = 1'b1;
            end
            if (sleep_instr) begin
                v[TIMEOUT_BIT] = 1'b1;
                v[POWER_DOWN_BIT] = 1'b0;
            end
            processor_condition_flags <= v;
        end
    end

    // ==========================================================
    // Bank decode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            direct_address <= 9'h000;
            indirect_address <= 9'h000;
        end else begin
            direct_address <= bank_base(processor_condition_flags[BANK_HI_BIT:BANK_LO_BIT]) +
                {2'h0, direct_offset[6:0]};
            indirect_address <= (processor_condition_flags[INDIRECT_BIT] ? INDIRECT_SIZE :
                9'h000) + {1'b0, indirect_pointer};
        end
    end

    assign processor_condition_flags_out = processor_condition_flags;
endmodule : status_flags
`default_nettype wire

// [rtl/status_flags_pkg.sv]
// Constants for the processor condition flags register and its Avalon-MM access.
// Assumes a single 25 MHz clock shared with the instruction execution unit.
//
// Operation
// - Indirect bank select one maps indirect accesses to 100h-1FFh, zero maps them to 00h-FFh.
// - The two-bit direct bank field at bits 6-5 picks bank 0 to 3 at 00h, 80h, 100h and 180h.
// - The timeout flag at bit 4 is set by power-up, the watchdog-clear and the sleep instruction.
// - The timeout flag is cleared when the watchdog timer expires.
// - The power-down flag at bit 3 is set by power-up and by the watchdog-clear instruction.
// - The power-down flag is cleared whenever the sleep instruction executes.
// - The zero flag at bit 2 is one for a zero arithmetic or logic result and zero otherwise.
// - The digit-carry flag at bit 1 shows a carry out of the fourth lowest result bit.
// - The carry flag at bit 0 shows a carry out of the most significant result bit.
// - Add-register, add-literal, subtract-from-literal and subtract-register update both carries.
// - In subtraction the carry and digit-carry flags read one when no borrow occurred.
// - Subtraction adds the two's complement of the second operand and takes flags from that sum.
// - Rotations load carry with the bit shifted out: low bit for right, high bit for left.
// - When the register is the destination of a flag-affecting operation the flag updates win.
`default_nettype none
package status_flags_pkg;
    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 4;
    localparam logic [ADDR_WIDTH-1:0] FLAGS_OFFSET = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] WORD_OFFSET = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] ALU_OFFSET = 4'h8;
    localparam int INDIRECT_BIT = 7;
    localparam int BANK_HI_BIT = 6;
    localparam int BANK_LO_BIT = 5;
    localparam int TIMEOUT_BIT = 4;
    localparam int POWER_DOWN_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int DIGIT_CARRY_BIT = 1;
    localparam int CARRY_BIT = 0;
    localparam logic [7:0] WRITABLE_MASK = 8'he7;
    localparam logic [7:0] FLAGS_RESET = 8'h18;
    localparam logic [8:0] BANK_SIZE = 9'h080;
    localparam logic [8:0] INDIRECT_SIZE = 9'h100;
    typedef enum logic [2:0] {
        op_none_type_v, op_add_reg, op_add_lit, op_sub_lit, op_sub_reg,
        op_rot_right, op_rot_left, op_logic
    } alu_op_type;
endpackage : status_flags_pkg
`default_nettype wire

// [rtl/flag_alu.sv]
// Eight-bit adder and rotator that produces a result and its three condition flags.
// Assumes it is driven combinationally from the status register block.
`default_nettype none
module flag_alu (
    input wire status_flags_pkg::alu_op_type op,
    input wire logic [7:0] operand_a,
    input wire logic [7:0] operand_b,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic zero,
    output logic digit_carry,
    output logic carry,
    output logic carries_valid,
    output logic carry_valid
);
    import status_flags_pkg::*;
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    logic [7:0] addend;
    logic [7:0] minuend;
    always_comb begin
        addend = operand_b;
        minuend = operand_a;
        if (op == op_sub_lit || op == op_sub_reg) begin
            addend = ~operand_b;
        end
        low_sum = {1'b0, minuend[3:0]} + {1'b0, addend[3:0]} + {4'h0, (op == op_sub_lit ||
            op == op_sub_reg)};
        full_sum = {1'b0, minuend} + {1'b0, addend} + {8'h00, (op == op_sub_lit ||
            op == op_sub_reg)};
        result = full_sum[7:0];
        digit_carry = low_sum[4];
        carry = full_sum[8];
        carries_valid = (op == op_add_reg || op == op_add_lit || op == op_sub_lit ||
            op == op_sub_reg);
        carry_valid = carries_valid;
        case (op)
            op_rot_right: begin
                result = {carry_in, operand_a[7:1]};
                carry = operand_a[0];
                carry_valid = 1'b1;
            end
            op_rot_left: begin
                result = {operand_a[6:0], carry_in};
                carry = operand_a[7];
                carry_valid = 1'b1;
            end
            op_logic: begin
                result = operand_a & operand_b;
            end
            default: begin
            end
        endcase
        zero = (result == 8'h00);
    end
endmodule : flag_alu
`default_nettype wire

// [bench/status_flags_sva.sv]
// Assertions on the condition flags block, bound to its top module.
// Assumes one clock and the asynchronous active-low reset.
`default_nettype none
module status_flags_sva
    import status_flags_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_waitrequest,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timer_expired,
    input wire status_flags_pkg::alu_op_type alu_op,
    input wire logic [7:0] alu_operand_a,
    input wire logic [7:0] alu_operand_b,
    input wire logic alu_start,
    input wire logic alu_dest_is_flags,
    input wire logic [8:0] direct_offset,
    input wire logic [7:0] indirect_pointer,
    input wire logic [8:0] direct_address,
    input wire logic [8:0] indirect_address,
    input wire logic [7:0] alu_result,
    input wire logic [7:0] processor_condition_flags_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] f, sum;
    logic [8:0] s;
    logic [4:0] h;
    logic [3:0] k;
    logic go;
    assign f = processor_condition_flags_out;
    assign s = {1'b0, alu_operand_a} + {1'b0, alu_operand_b};
    assign h = {1'b0, alu_operand_a[3:0]} + {1'b0, alu_operand_b[3:0]};
    assign sum = s[7:0];
    assign k = {h[4], s[8], alu_operand_a[7], alu_operand_a[0]};
    // Only a lone ALU request is judged, since events and write-back take priority.
    assign go = alu_start && !alu_dest_is_flags && !sleep_instr && !watchdog_clear_instr
        && !watchdog_timer_expired;
    // ========================================
    // Properties.
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_sleep; sleep_instr |=> f[4:3] == 2'b10; endproperty
    property p_clear; watchdog_clear_instr && !sleep_instr |=> f[4:3] == 2'b11; endproperty
    property p_expire;
        watchdog_timer_expired && !watchdog_clear_instr && !sleep_instr |=> !f[4];
    endproperty
    property p_keep;
        !sleep_instr && !watchdog_clear_instr |=> $stable(f[3]) && !$rose(f[4]);
    endproperty
    property p_add;
        go && alu_op == op_add_reg |=> f[1:0] == $past(k[3:2]) && alu_result == $past(sum);
    endproperty
    property p_rotl; go && alu_op == op_rot_left |=> f[0] == $past(k[1]); endproperty
    property p_rotr; go && alu_op == op_rot_right |=> f[0] == $past(k[0]); endproperty
    property p_direct;
        1'b1 |-> direct_address == {$past(f[6:5]), $past(direct_offset[6:0])};
    endproperty
    property p_indirect; 1'b1 |-> indirect_address == {$past(f[7]), $past(indirect_pointer)};
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    a_clear: assert property (p_clear) else $error("clear flags wrong");
    a_expire: assert property (p_expire) else $error("expiry flag wrong");
    a_keep: assert property (p_keep) else $error("power flags moved");
    a_add: assert property (p_add) else $error("add flags wrong");
    a_rotl: assert property (p_rotl) else $error("rotate left carry wrong");
    a_rotr: assert property (p_rotr) else $error("rotate right carry wrong");
    a_direct: assert property (p_direct) else $error("direct address wrong");
    a_indirect: assert property (p_indirect) else $error("indirect address wrong");
    c_sleep: cover property (sleep_instr);
    c_dest: cover property (alu_start && alu_dest_is_flags);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule : status_flags_sva
bind status_flags status_flags_sva u_sva (.clk, .reset_n, .avs_read, .avs_waitrequest,
    .watchdog_clear_instr, .sleep_instr, .watchdog_timer_expired, .alu_op, .alu_operand_a,
    .alu_operand_b, .alu_start, .alu_dest_is_flags, .direct_offset, .indirect_pointer,
    .direct_address, .indirect_address, .alu_result, .processor_condition_flags_out);
`default_nettype wire

// [bench/exec_model.sv]
// Stand-in for the instruction execution unit that issues events and ALU requests.
// Assumes the bench calls issue from one process only.
`default_nettype none
module exec_model
    import status_flags_pkg::*;
(
    input wire logic clk,
    output logic watchdog_clear_instr,
    output logic sleep_instr,
    output logic watchdog_timer_expired,
    output status_flags_pkg::alu_op_type alu_op,
    output logic [7:0] alu_operand_a,
    output logic [7:0] alu_operand_b,
    output logic alu_start,
    output logic alu_dest_is_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {sleep_instr, watchdog_clear_instr, watchdog_timer_expired, alu_start} = 4'h0;
        {alu_operand_a, alu_operand_b, alu_dest_is_flags} = 17'h0;
        alu_op = op_none_type_v;
    end
    // Operands are inverted after each pulse so stale values are never trusted.
    task automatic issue(input logic [2:0] ev, input alu_op_type op, input logic [7:0] a,
        input logic [7:0] b, input logic dst);
        @(posedge clk);
        {sleep_instr, watchdog_clear_instr, watchdog_timer_expired} <= ev;
        alu_op <= op;
        alu_operand_a <= a;
        alu_operand_b <= b;
        alu_dest_is_flags <= dst;
        alu_start <= (op != op_none_type_v);
        @(posedge clk);
        {sleep_instr, watchdog_clear_instr, watchdog_timer_expired, alu_start} <= 4'h0;
        alu_dest_is_flags <= 1'b0;
        alu_operand_a <= ~a;
        alu_operand_b <= ~b;
    endtask : issue
endmodule : exec_model
`default_nettype wire

// [bench/tb_status_flags.sv]
// Self-checking bench for the condition flags block against an integer model.
// Assumes the execution unit stand-in and the bound checker.
`default_nettype none
module tb_status_flags;
    timeunit 1ns;
    timeprecision 1ns;
    import status_flags_pkg::*;
    logic clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [1:0] avs_response, rs;
    logic watchdog_clear_instr, sleep_instr, watchdog_timer_expired, alu_start;
    logic alu_dest_is_flags;
    alu_op_type alu_op;
    logic [7:0] alu_operand_a, alu_operand_b, alu_result, processor_condition_flags_out;
    logic [7:0] indirect_pointer = 8'h0;
    logic [8:0] direct_offset = 9'h0, direct_address, indirect_address;
    logic [2:0] evs [6] = '{3'b100, 3'b001, 3'b010, 3'b001, 3'b110, 3'b011};
    int error_cnt = 0, tests_run = 0, cyc = 0, m = 8'h18, r = 0, sc = 0;
    int unsigned x = 96;
    status_flags DUT (.*, .avs_byteenable(4'hf));
    exec_model u_exec (.*);
    always #20 clk = ~clk;
    // ========================================
    // Shared tasks.
    function automatic int unsigned rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : rnd
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic alu(input logic [2:0] ev, input alu_op_type o, input int p, input int s,
        input logic d);
        int c, t, ci;
        c = m & 1;
        ci = (o == op_sub_lit || o == op_sub_reg);
        t = ci ? ~s & 255 : s;
        if (o >= op_add_reg && o <= op_sub_reg) begin
            r = (p + t + ci) & 255;
            m = m & 8'hf8 | (r == 0) << 2 | (p + t + ci > 255);
            m = m | ((p & 15) + (t & 15) + ci > 15) << 1;
        end else if (o == op_rot_left) begin
            r = (p << 1 | c) & 255;
            m = m & 8'hfe | p >> 7;
        end else if (o == op_rot_right) begin
            r = p >> 1 | c << 7;
            m = m & 8'hfe | p & 1;
        end else if (o == op_logic) begin
            r = p & s;
            m = m & 8'hfb | (r == 0) << 2;
        end
        if (d) m = m & 8'h1f | r & 8'he0;
        if (ev[0]) m = m & 8'hef;
        if (ev[1]) m = m | 8'h18;
        if (ev[2]) m = m & 8'he7 | 8'h10;
        u_exec.issue(ev, o, 8'(p), 8'(s), d);
        @(negedge clk);
        chk("flags", processor_condition_flags_out, m);
        if (o != op_none_type_v) chk("result", alu_result, r);
    endtask : alu
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
    // ========================================
    // Scenarios.
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("reset", processor_condition_flags_out, 8'h18);
        foreach (evs[i]) alu(evs[i], op_none_type_v, 0, 0, 0);
        alu(0, op_add_reg, 8'h0f, 8'h01, 0);
        alu(0, op_add_lit, 8'hff, 8'h01, 0);
        alu(0, op_sub_reg, 8'h05, 8'h05, 0);
        alu(0, op_sub_lit, 8'h00, 8'h01, 0);
        for (int i = 0; i < 60; i++) begin
            alu(0, alu_op_type'(1 + rnd() % 7), rnd() & 255, rnd() & 255, 0);
        end
        bus(1, FLAGS_OFFSET, 8'hff);
        m = m & 8'h18 | 8'he7;
        sc = rnd() & 255;
        bus(1, WORD_OFFSET, 8'(sc));
        bus(0, WORD_OFFSET, 8'h00);
        chk("scratch", q, sc);
        bus(1, 4'hc, 8'h5a);
        chk("write response", rs, 2);
        bus(0, FLAGS_OFFSET, 8'h00);
        chk("write", q, m);
        chk("read response", rs, 0);
        alu(0, op_logic, 8'hff, 8'h00, 1);
        for (int i = 0; i < 8; i++) begin
            bus(1, FLAGS_OFFSET, 8'(i << 5));
            m = m & 8'h18 | i << 5;
            direct_offset <= 9'(rnd());
            indirect_pointer <= 8'(rnd());
            repeat (2) @(negedge clk);
            chk("direct", direct_address, {m[6:5], direct_offset[6:0]});
            chk("indirect", indirect_address, {m[7], indirect_pointer});
        end
        bus(0, ALU_OFFSET, 8'h00);
        chk("last", q, r);
        bus(0, 4'hc, 8'h00);
        chk("unmapped", q, 0);
        chk("response", rs, 2);
        conclude();
    end
endmodule : tb_status_flags
`default_nettype wire
